//--- rtl/fsr_pkg.sv
package fsr_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int RESUME_WIP_NS = 200;
	localparam logic [1:0] RESUME_WIP_CYC = 2'(RESUME_WIP_NS / CLK_PERIOD_NS);
	localparam int SEC_BYTES = 512;
	localparam int SEC_COUNT = 3;

	// ----------------------------------------
	// opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_STAT_INT = 8'h25;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7A;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_PP_DUAL = 8'hA2;
	localparam logic [7:0] OP_PP_QUAD = 8'h32;
	localparam logic [7:0] OP_PE_A = 8'h81;
	localparam logic [7:0] OP_PE_B = 8'hDB;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64 = 8'hD8;
	localparam logic [7:0] OP_SEC_ERASE = 8'h44;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FREAD = 8'h0B;
	localparam logic [7:0] OP_DOREAD = 8'h3B;
	localparam logic [7:0] OP_DIOREAD = 8'hBB;
	localparam logic [7:0] OP_QOREAD = 8'h6B;
	localparam logic [7:0] OP_QIOREAD = 8'hEB;

	// ----------------------------------------
	// frame lengths, status bits, regions
	// ----------------------------------------
	localparam logic [5:0] CMD_BITS = 6'h08;
	localparam logic [5:0] ADDR_END = 6'h20;
	localparam logic [5:0] DATA_END = 6'h28;
	localparam int ST_WIP = 0;
	localparam int ST_WEL = 1;
	localparam int ST_ERASE_PAUSED_FLAG = 10;
	localparam int ST_LB_LO = 11;
	localparam int ST_PROGRAM_PAUSED_FLAG = 15;
	localparam logic [23:0] MASK_PAGE = 24'hFFFF00;
	localparam logic [23:0] MASK_SECTOR = 24'hFFF000;
	localparam logic [23:0] MASK_32K = 24'hFF8000;
	localparam logic [23:0] MASK_64K = 24'hFF0000;

	// ----------------------------------------
	// host register map
	// ----------------------------------------
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h4;
	localparam logic [3:0] REG_DATA = 4'h8;
	localparam logic [3:0] REG_STAT = 4'hC;
	localparam int CMD_HAS_ADDR = 8;
	localparam int CMD_HAS_DATA = 9;
	localparam int CMD_READ = 10;

	typedef enum logic [1:0] {K_PROG = 2'b00, K_ERASE = 2'b01, K_SEC = 2'b10} fsr_kind_t;
	typedef enum logic [2:0] {H_IDLE = 3'b000, H_HOLD = 3'b001, H_LOW = 3'b010, H_HIGH = 3'b011,
		H_TAIL = 3'b100} fsr_hstate_t;

	function automatic logic [31:0] us_to_cyc(input int us);
		int c;
		c = (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return 32'(c < 1 ? 1 : c);
	endfunction

	function automatic logic no_latency_op(input logic [7:0] op);
		return op == OP_RDSR1 || op == OP_RDSR2 || op == OP_STAT_INT || op == OP_RST_EN || op == OP_RST;
	endfunction
endpackage

//--- rtl/fsr_spi_if.sv
`timescale 1ns/1ps
interface fsr_spi_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso;
	modport dev (input cs_n, input sclk, input mosi, output miso);
	modport host (output cs_n, output sclk, output mosi, input miso);
endinterface

//--- rtl/fsr_edge_sync.sv
`timescale 1ns/1ps
module fsr_edge_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// meta_q feeds sync_q only
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
			prev_q <= RST_VAL;
		end
		else
		begin
			meta_q <= din;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;
endmodule

//--- rtl/fsr_flash_dev.sv
`timescale 1ns/1ps
// Summary of operation
// - suspend opcode pauses running program or erase
// - reads refused inside the suspended region
// - erase suspend allows write enable and programs
// - status write and secreg erase never suspend
// - pause latency, then clear latch, set flag
// - bit 15 program paused, bit 10 erase paused
// - listed commands accepted after pause latency
// - status, interrupt, reset accepted without latency
// - resume accepted only when paused and idle
// - resume clears flag, busy within bound, finishes
// - resume ignored when not paused or busy
// - resume ignored after power loss
// - host waits minimum gap before next suspend
// - three separately erasable 512-byte security registers
// - secreg erase needs latch, opcode, 24-bit address
// - secreg chosen by address bits 15..12
// - select must rise right after last bit
// - self-timed erase keeps busy, status readable
// - erase end clears busy and latch
// - lock bit set blocks its secreg erase
module fsr_flash_dev #(
	parameter int PROG_TIME_US = 2000,
	parameter int ERASE_TIME_US = 8000,
	parameter int SEC_ERASE_TIME_US = 8000,
	parameter int PROG_PAUSE_US = 20,
	parameter int ERASE_PAUSE_US = 20
)
(
	input wire logic ref_clk,
	input wire logic rst,
	fsr_spi_if.dev spi,
	input wire logic power_lost,
	input wire logic [2:0] otp_lock_bits,
	output logic [15:0] status_word,
	output logic access_refused,
	output logic [2:0] secreg_erased
);
	localparam logic [31:0] PROG_CYC = fsr_pkg::us_to_cyc(PROG_TIME_US);
	localparam logic [31:0] ERASE_CYC = fsr_pkg::us_to_cyc(ERASE_TIME_US);
	localparam logic [31:0] SEC_CYC = fsr_pkg::us_to_cyc(SEC_ERASE_TIME_US);
	localparam logic [31:0] PSL_CYC = fsr_pkg::us_to_cyc(PROG_PAUSE_US);
	localparam logic [31:0] ESL_CYC = fsr_pkg::us_to_cyc(ERASE_PAUSE_US);

	logic [2:0] lvl;
	logic [2:0] rise;
	logic [2:0] fall;
	logic in_frame;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic [5:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] opcode_q;
	logic [23:0] addr_q;
	logic [7:0] byte_now;
	logic [23:0] addr_now;
	logic [7:0] tx_q;
	logic miso_q;
	logic run_q;
	logic pausing_q;
	logic prog_p_q;
	logic erase_p_q;
	logic lost_q;
	logic wel_q;
	logic rst_en_q;
	logic lock_cap_q;
	logic [2:0] lock_q;
	logic [1:0] resume_cnt_q;
	fsr_pkg::fsr_kind_t run_kind_q;
	fsr_pkg::fsr_kind_t held_kind_q;
	logic [31:0] run_cnt_q;
	logic [31:0] held_cnt_q;
	logic [31:0] pause_cnt_q;
	logic [23:0] run_base_q;
	logic [23:0] run_mask_q;
	logic [23:0] held_base_q;
	logic [23:0] held_mask_q;
	logic [2:0] sec_sel_q;
	logic [2:0] sec_onehot;
	logic [15:0] status_d;
	logic [7:0] stat_byte;
	logic write_in_progress;
	logic len_ok;
	logic cmd_go;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic region_hit(input logic [23:0] a, input logic [23:0] base, input logic [23:0] mask);
		return (a & mask) == (base & mask);
	endfunction

	function automatic logic is_read(input logic [7:0] op);
		return op == fsr_pkg::OP_READ || op == fsr_pkg::OP_FREAD || op == fsr_pkg::OP_DOREAD
			|| op == fsr_pkg::OP_DIOREAD || op == fsr_pkg::OP_QOREAD || op == fsr_pkg::OP_QIOREAD;
	endfunction

	function automatic logic is_prog(input logic [7:0] op);
		return op == fsr_pkg::OP_PP || op == fsr_pkg::OP_PP_DUAL || op == fsr_pkg::OP_PP_QUAD;
	endfunction

	function automatic logic [23:0] erase_mask(input logic [7:0] op);
		case (op)
			fsr_pkg::OP_SE: return fsr_pkg::MASK_SECTOR;
			fsr_pkg::OP_BE32: return fsr_pkg::MASK_32K;
			fsr_pkg::OP_BE64: return fsr_pkg::MASK_64K;
			fsr_pkg::OP_PE_A, fsr_pkg::OP_PE_B: return fsr_pkg::MASK_PAGE;
			default: return '0;
		endcase
	endfunction

	// whether an opcode is honoured in the present suspend mode
	function automatic logic op_ok(input logic [7:0] op, input logic busy, input logic can_pause,
		input logic prog_p, input logic erase_p);
		if (fsr_pkg::no_latency_op(op))
			return 1'b1;
		else if (busy)
			return op == fsr_pkg::OP_SUSPEND && can_pause;
		else if (prog_p || erase_p)
		begin
			if (is_read(op))
				return 1'b1;
			case (op)
				8'h5A, 8'h9F, 8'h90, 8'h92, 8'h94, 8'h48, 8'h77, 8'h04, 8'h7A, 8'hAB: return 1'b1;
				8'h06, 8'h02, 8'hA2, 8'h32: return erase_p;
				default: return 1'b0;
			endcase
		end
		else
			return 1'b1;
	endfunction

	// ----------------------------------------
	// link sampling
	// ----------------------------------------
	fsr_edge_sync #(.W(3), .RST_VAL(3'b100)) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.din({spi.cs_n, spi.sclk, spi.mosi}),
		.level(lvl),
		.rise(rise),
		.fall(fall)
	);

	assign in_frame = ~lvl[2];
	assign sclk_rise = rise[1] & in_frame;
	assign sclk_fall = fall[1] & in_frame;
	assign cs_rise = rise[2];
	assign byte_now = {shift_q[6:0], lvl[0]};
	assign addr_now = {addr_q[22:0], lvl[0]};
	assign spi.miso = miso_q;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			bit_cnt_q <= '0;
			shift_q <= '0;
			opcode_q <= '0;
			addr_q <= '0;
		end
		else if (fall[2])
			bit_cnt_q <= '0;
		else if (sclk_rise)
		begin
			shift_q <= byte_now;
			// data bytes wrap the count so byte alignment stays visible
			if (bit_cnt_q == fsr_pkg::DATA_END + 6'h07)
				bit_cnt_q <= fsr_pkg::DATA_END;
			else
				bit_cnt_q <= bit_cnt_q + 6'h01;
			if (bit_cnt_q == fsr_pkg::CMD_BITS - 6'h01)
				opcode_q <= byte_now;
			if (bit_cnt_q >= fsr_pkg::CMD_BITS && bit_cnt_q < fsr_pkg::ADDR_END)
				addr_q <= addr_now;
		end
	end

	// ----------------------------------------
	// status and its shift-out
	// ----------------------------------------
	assign write_in_progress = run_q | pausing_q;

	always_comb
	begin
		status_d = '0;
		status_d[fsr_pkg::ST_WIP] = write_in_progress;
		status_d[fsr_pkg::ST_WEL] = wel_q;
		status_d[fsr_pkg::ST_ERASE_PAUSED_FLAG] = erase_p_q;
		status_d[fsr_pkg::ST_LB_LO +: 3] = lock_q;
		status_d[fsr_pkg::ST_PROGRAM_PAUSED_FLAG] = prog_p_q;
	end

	assign stat_byte = (opcode_q == fsr_pkg::OP_RDSR2) ? status_d[15:8] : status_d[7:0];

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			miso_q <= 1'b0;
			tx_q <= '0;
			status_word <= '0;
		end
		else
		begin
			status_word <= status_d;
			if (sclk_fall && bit_cnt_q >= fsr_pkg::CMD_BITS
				&& (opcode_q == fsr_pkg::OP_RDSR1 || opcode_q == fsr_pkg::OP_RDSR2))
			begin
				// status stays readable through every busy phase
				if (bit_cnt_q[2:0] == 3'h0)
				begin
					miso_q <= stat_byte[7];
					tx_q <= {stat_byte[6:0], 1'b0};
				end
				else
				begin
					miso_q <= tx_q[7];
					tx_q <= {tx_q[6:0], 1'b0};
				end
			end
			else if (!in_frame)
				miso_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// lock bits, caught once after reset
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			lock_cap_q <= 1'b0;
			lock_q <= '0;
		end
		else if (!lock_cap_q)
		begin
			lock_cap_q <= 1'b1;
			lock_q <= otp_lock_bits;
		end
	end

	// ----------------------------------------
	// command execution at select release
	// ----------------------------------------
	always_comb
	begin
		sec_onehot = '0;
		if (addr_q[23:16] == 8'h00 && addr_q[11:9] == 3'h0)
		begin
			case (addr_q[15:12])
				4'h1: sec_onehot = 3'b001;
				4'h2: sec_onehot = 3'b010;
				4'h3: sec_onehot = 3'b100;
				default: sec_onehot = 3'b000;
			endcase
		end
	end

	always_comb
	begin
		if (is_prog(opcode_q))
			len_ok = bit_cnt_q == fsr_pkg::DATA_END;
		else if (erase_mask(opcode_q) != '0 || opcode_q == fsr_pkg::OP_SEC_ERASE)
			len_ok = bit_cnt_q == fsr_pkg::ADDR_END;
		else
			len_ok = bit_cnt_q == fsr_pkg::CMD_BITS;
	end

	assign cmd_go = cs_rise && len_ok && op_ok(opcode_q, write_in_progress, run_q && !pausing_q && run_kind_q != fsr_pkg::K_SEC
		&& !prog_p_q && !erase_p_q, prog_p_q, erase_p_q);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			run_q <= 1'b0;
			pausing_q <= 1'b0;
			prog_p_q <= 1'b0;
			erase_p_q <= 1'b0;
			lost_q <= 1'b0;
			wel_q <= 1'b0;
			rst_en_q <= 1'b0;
			resume_cnt_q <= '0;
			run_kind_q <= fsr_pkg::K_PROG;
			held_kind_q <= fsr_pkg::K_PROG;
			run_cnt_q <= '0;
			held_cnt_q <= '0;
			pause_cnt_q <= '0;
			run_base_q <= '0;
			run_mask_q <= '0;
			held_base_q <= '0;
			held_mask_q <= '0;
			sec_sel_q <= '0;
			access_refused <= 1'b0;
			secreg_erased <= '0;
		end
		else
		begin
			access_refused <= 1'b0;
			secreg_erased <= '0;
			if (resume_cnt_q != 2'h0)
			begin
				resume_cnt_q <= resume_cnt_q - 2'h1;
				if (resume_cnt_q == 2'h1)
				begin
					run_q <= 1'b1;
					run_kind_q <= held_kind_q;
					run_cnt_q <= held_cnt_q;
					run_base_q <= held_base_q;
					run_mask_q <= held_mask_q;
				end
			end
			if (run_q && !pausing_q)
			begin
				if (run_cnt_q == 32'h1)
				begin
					run_q <= 1'b0;
					wel_q <= 1'b0;
					if (run_kind_q == fsr_pkg::K_SEC)
						secreg_erased <= sec_sel_q;
				end
				else
					run_cnt_q <= run_cnt_q - 32'h1;
			end
			if (pausing_q)
			begin
				if (pause_cnt_q == 32'h1)
				begin
					pausing_q <= 1'b0;
					run_q <= 1'b0;
					wel_q <= 1'b0;
					prog_p_q <= run_kind_q == fsr_pkg::K_PROG;
					erase_p_q <= run_kind_q == fsr_pkg::K_ERASE;
					held_kind_q <= run_kind_q;
					held_cnt_q <= run_cnt_q;
					held_base_q <= run_base_q;
					held_mask_q <= run_mask_q;
				end
				else
					pause_cnt_q <= pause_cnt_q - 32'h1;
			end
			if (sclk_rise && bit_cnt_q == fsr_pkg::ADDR_END - 6'h01 && is_read(opcode_q)
				&& (prog_p_q || erase_p_q) && region_hit(addr_now, held_base_q, held_mask_q))
				access_refused <= 1'b1;
			if (cmd_go)
			begin
				rst_en_q <= 1'b0;
				case (opcode_q)
					fsr_pkg::OP_WREN: wel_q <= 1'b1;
					fsr_pkg::OP_WRDI: wel_q <= 1'b0;
					fsr_pkg::OP_RST_EN: rst_en_q <= 1'b1;
					fsr_pkg::OP_RST:
					begin
						if (rst_en_q)
						begin
							wel_q <= 1'b0;
							run_q <= 1'b0;
							pausing_q <= 1'b0;
							prog_p_q <= 1'b0;
							erase_p_q <= 1'b0;
							lost_q <= 1'b0;
							resume_cnt_q <= '0;
						end
					end
					fsr_pkg::OP_SUSPEND:
					begin
						pausing_q <= 1'b1;
						pause_cnt_q <= (run_kind_q == fsr_pkg::K_PROG) ? PSL_CYC : ESL_CYC;
					end
					fsr_pkg::OP_RESUME:
					begin
						// busy bit is checked through op_ok; only the flag and loss remain
						if ((prog_p_q || erase_p_q) && !lost_q)
						begin
							prog_p_q <= 1'b0;
							erase_p_q <= 1'b0;
							resume_cnt_q <= fsr_pkg::RESUME_WIP_CYC;
						end
					end
					fsr_pkg::OP_SEC_ERASE:
					begin
						if (wel_q && sec_onehot != '0 && (sec_onehot & lock_q) == '0)
						begin
							run_q <= 1'b1;
							run_kind_q <= fsr_pkg::K_SEC;
							run_cnt_q <= SEC_CYC;
							sec_sel_q <= sec_onehot;
						end
					end
					default:
					begin
						if (is_prog(opcode_q) && wel_q)
						begin
							if (erase_p_q && region_hit(addr_q, held_base_q, held_mask_q))
								access_refused <= 1'b1;
							else
							begin
								run_q <= 1'b1;
								run_kind_q <= fsr_pkg::K_PROG;
								run_cnt_q <= PROG_CYC;
								run_base_q <= addr_q;
								run_mask_q <= fsr_pkg::MASK_PAGE;
							end
						end
						else if (erase_mask(opcode_q) != '0 && wel_q)
						begin
							run_q <= 1'b1;
							run_kind_q <= fsr_pkg::K_ERASE;
							run_cnt_q <= ERASE_CYC;
							run_base_q <= addr_q;
							run_mask_q <= erase_mask(opcode_q);
						end
					end
				endcase
			end
			if (power_lost)
			begin
				// the held operation keeps its paused flag and held region; lost_q blocks its resume
				run_q <= 1'b0;
				pausing_q <= 1'b0;
				resume_cnt_q <= '0;
				lost_q <= 1'b1;
			end
		end
	end
endmodule

//--- rtl/fsr_spi_host.sv
`timescale 1ns/1ps
module fsr_spi_host #(
	parameter int HALF_DIV = 4,
	parameter int PAUSE_WAIT_US = 20,
	parameter int RESUME_GAP_US = 100
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	fsr_spi_if.host spi
);
	localparam logic [31:0] LAT_CYC = fsr_pkg::us_to_cyc(PAUSE_WAIT_US);
	localparam logic [31:0] GAP_CYC = fsr_pkg::us_to_cyc(RESUME_GAP_US);
	localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);

	fsr_pkg::fsr_hstate_t st_q;
	logic [10:0] cmd_q;
	logic [23:0] addr_q;
	logic [7:0] wdata_q;
	logic [7:0] rx_q;
	logic [39:0] tx_q;
	logic [5:0] nbits_q;
	logic [5:0] cnt_q;
	logic [7:0] div_q;
	logic busy_q;
	logic start_q;
	logic [31:0] lat_q;
	logic [31:0] gap_q;
	logic tick;
	logic stall;
	logic [0:0] miso_s;
	logic cs_n_q;
	logic sclk_q;
	logic mosi_q;

	assign spi.cs_n = cs_n_q;
	assign spi.sclk = sclk_q;
	assign spi.mosi = mosi_q;

	fsr_edge_sync #(.W(1), .RST_VAL(1'b0)) u_miso_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.din(spi.miso),
		.level(miso_s),
		.rise(),
		.fall()
	);

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	// a command write stalls while a frame is still running
	assign stall = avs_write && avs_address == fsr_pkg::REG_CMD && (busy_q || start_q);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end
		else if ((avs_read || avs_write) && avs_waitrequest && !stall)
		begin
			avs_waitrequest <= 1'b0;
			case (avs_address)
				fsr_pkg::REG_CMD: avs_readdata <= {21'h0, cmd_q};
				fsr_pkg::REG_ADDR: avs_readdata <= {8'h00, addr_q};
				fsr_pkg::REG_DATA: avs_readdata <= {24'h0, wdata_q};
				fsr_pkg::REG_STAT: avs_readdata <= {16'h0, rx_q, 7'h0, busy_q};
				default: avs_readdata <= '0;
			endcase
		end
		else
			avs_waitrequest <= 1'b1;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cmd_q <= '0;
			addr_q <= '0;
			wdata_q <= '0;
			start_q <= 1'b0;
		end
		else
		begin
			start_q <= 1'b0;
			if (avs_write && !avs_waitrequest)
			begin
				case (avs_address)
					fsr_pkg::REG_CMD:
					begin
						cmd_q <= avs_writedata[10:0];
						start_q <= 1'b1;
					end
					fsr_pkg::REG_ADDR: addr_q <= avs_writedata[23:0];
					fsr_pkg::REG_DATA: wdata_q <= avs_writedata[7:0];
					default: start_q <= 1'b0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// latency and gap timers
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			lat_q <= '0;
			gap_q <= '0;
		end
		else if (st_q == fsr_pkg::H_TAIL && tick && cmd_q[7:0] == fsr_pkg::OP_SUSPEND)
			lat_q <= LAT_CYC;
		else if (st_q == fsr_pkg::H_TAIL && tick && cmd_q[7:0] == fsr_pkg::OP_RESUME)
			gap_q <= GAP_CYC;
		else
		begin
			if (lat_q != '0)
				lat_q <= lat_q - 32'h1;
			if (gap_q != '0)
				gap_q <= gap_q - 32'h1;
		end
	end

	// ----------------------------------------
	// frame engine, mode 0, msb first
	// ----------------------------------------
	assign tick = div_q == DIV_LAST;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			div_q <= '0;
		else if (st_q == fsr_pkg::H_IDLE || st_q == fsr_pkg::H_HOLD || tick)
			div_q <= '0;
		else
			div_q <= div_q + 8'h01;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= fsr_pkg::H_IDLE;
			busy_q <= 1'b0;
			tx_q <= '0;
			nbits_q <= '0;
			cnt_q <= '0;
			rx_q <= '0;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
			mosi_q <= 1'b0;
		end
		else
		begin
			case (st_q)
				fsr_pkg::H_IDLE:
				begin
					if (start_q)
					begin
						busy_q <= 1'b1;
						tx_q <= cmd_q[fsr_pkg::CMD_HAS_ADDR] ? {cmd_q[7:0], addr_q, wdata_q}
							: {cmd_q[7:0], wdata_q, 24'h0};
						nbits_q <= fsr_pkg::CMD_BITS + (cmd_q[fsr_pkg::CMD_HAS_ADDR] ? 6'h18 : 6'h00)
							+ (cmd_q[fsr_pkg::CMD_HAS_DATA] ? 6'h08 : 6'h00)
							+ (cmd_q[fsr_pkg::CMD_READ] ? 6'h08 : 6'h00);
						cnt_q <= '0;
						st_q <= fsr_pkg::H_HOLD;
					end
				end
				fsr_pkg::H_HOLD:
				begin
					if (!(cmd_q[7:0] == fsr_pkg::OP_SUSPEND && gap_q != '0)
						&& !(!fsr_pkg::no_latency_op(cmd_q[7:0]) && lat_q != '0))
					begin
						cs_n_q <= 1'b0;
						mosi_q <= tx_q[39];
						tx_q <= {tx_q[38:0], 1'b0};
						st_q <= fsr_pkg::H_LOW;
					end
				end
				fsr_pkg::H_LOW:
				begin
					if (tick)
					begin
						sclk_q <= 1'b1;
						cnt_q <= cnt_q + 6'h01;
						st_q <= fsr_pkg::H_HIGH;
					end
				end
				fsr_pkg::H_HIGH:
				begin
					if (tick)
					begin
						// sampled late in the high phase to cover both synchronisers
						rx_q <= {rx_q[6:0], miso_s[0]};
						sclk_q <= 1'b0;
						mosi_q <= tx_q[39];
						tx_q <= {tx_q[38:0], 1'b0};
						st_q <= (cnt_q == nbits_q) ? fsr_pkg::H_TAIL : fsr_pkg::H_LOW;
					end
				end
				fsr_pkg::H_TAIL:
				begin
					if (tick)
					begin
						cs_n_q <= 1'b1;
						mosi_q <= 1'b0;
						busy_q <= 1'b0;
						st_q <= fsr_pkg::H_IDLE;
					end
				end
				default: st_q <= fsr_pkg::H_IDLE;
			endcase
		end
	end
endmodule

//--- verification/fsr_link_monitor.sv
`timescale 1ns/1ps
module fsr_link_monitor (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic [15:0] status_word,
	input wire logic [2:0] secreg_erased
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic paused;
	assign paused = status_word[10] | status_word[15];
	a_miso_idle_low: assert property (cs_n |-> !miso) else $error("miso busy");
	a_sclk_idle_low: assert property (cs_n && $past(cs_n) |-> !sclk) else $error("sclk busy");
	a_mosi_hold_high: assert property (sclk && $past(sclk) |-> $stable(mosi)) else $error("mosi moved");
	a_pause_goes_idle: assert property ($rose(paused) |-> !status_word[0] && !status_word[1])
		else $error("pause not idle");
	a_resume_busy_soon: assert property ($fell(status_word[10]) |-> ##[1:3] status_word[0])
		else $error("resume late");
	a_done_clears_latch: assert property ($fell(status_word[0]) |-> !status_word[1])
		else $error("latch kept");
	a_secreg_one_hot: assert property ($onehot0(secreg_erased)) else $error("two secregs");
	a_lock_blocks_erase: assert property ((secreg_erased & status_word[13:11]) == 3'h0)
		else $error("locked erased");
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic power_lost = 1'b0;
	logic [15:0] status_word;
	logic [2:0] secreg_erased;
	logic [31:0] q;
	logic [23:0] sec_addr [4] = '{24'h001000, 24'h002000, 24'h003000, 24'h001800};
	int miscompares = 0;
	int checks_done = 0;
	int refusals = 0;
	logic [2:0] lock_bits = 3'h4;
	logic access_refused;
	fsr_spi_if spi ();
	fsr_flash_dev #(.PROG_TIME_US(100), .ERASE_TIME_US(100), .SEC_ERASE_TIME_US(50)) u_fsr_flash_dev (
		.ref_clk(ref_clk), .rst(rst), .spi(spi), .power_lost(power_lost), .otp_lock_bits(lock_bits),
		.status_word(status_word), .access_refused(access_refused), .secreg_erased(secreg_erased));
	fsr_spi_host #(.RESUME_GAP_US(5)) u_fsr_spi_host (.ref_clk(ref_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .spi(spi));
	fsr_link_monitor u_fsr_link_monitor (.ref_clk(ref_clk), .rst(rst), .cs_n(spi.cs_n), .sclk(spi.sclk),
		.mosi(spi.mosi), .miso(spi.miso), .status_word(status_word), .secreg_erased(secreg_erased));
	initial forever #50 ref_clk = ~ref_clk;
	// refusals are one-cycle pulses, so they are counted as they pass
	always @(posedge ref_clk)
	begin
		if (access_refused === 1'b1)
			refusals <= refusals + 1;
	end
	task automatic wrap_up();
		if (miscompares == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic lapse(input int n);
		if (n >= 9999)
		begin
			miscompares++;
			wrap_up();
		end
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 9999);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		lapse(n);
	endtask
	// ----------------------------------------
	// one frame, then settle past the cs rise
	// ----------------------------------------
	task automatic cmd(input logic [7:0] op, input logic [2:0] fl, input logic [23:0] a);
		int n = 0;
		av(1'b1, fsr_pkg::REG_ADDR, {8'h00, a});
		av(1'b1, fsr_pkg::REG_CMD, {21'h0, fl, op});
		do
		begin
			av(1'b0, fsr_pkg::REG_STAT, 32'h0);
			n += 25;
		end
		while (q[0] !== 1'b0 && n < 9999);
		repeat (6) @(posedge ref_clk);
		lapse(n);
	endtask
	task automatic wren();
		cmd(fsr_pkg::OP_WREN, 3'h0, 24'h0);
	endtask
	task automatic rdsr();
		cmd(fsr_pkg::OP_RDSR1, 3'h4, 24'h0);
		av(1'b0, fsr_pkg::REG_STAT, 32'h0);
	endtask
	task automatic wt();
		int n = 0;
		while (status_word[0] !== 1'b0 && n < 9999)
		begin
			@(posedge ref_clk);
			n++;
		end
		repeat (2) @(posedge ref_clk);
		lapse(n);
	endtask
	initial
	begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk(status_word, 16'h2000);
		wren();
		cmd(fsr_pkg::OP_SE, 3'h1, 24'h001000);
		cmd(fsr_pkg::OP_SUSPEND, 3'h0, 24'h0);
		// default pause latency of 200 cycles plus margin
		repeat (210) @(posedge ref_clk);
		chk(status_word, 16'h2400);
		wren();
		chk(status_word, 16'h2402);
		cmd(fsr_pkg::OP_SEC_ERASE, 3'h1, 24'h001000);
		chk(status_word, 16'h2402);
		cmd(fsr_pkg::OP_READ, 3'h5, 24'h001040);
		cmd(fsr_pkg::OP_READ, 3'h5, 24'h002000);
		cmd(fsr_pkg::OP_PP, 3'h3, 24'h001080);
		chk(16'(refusals), 16'h2);
		chk(status_word, 16'h2402);
		rdsr();
		chk(16'(q[15:8]), 16'h02);
		cmd(fsr_pkg::OP_RESUME, 3'h0, 24'h0);
		chk(16'({status_word[10], status_word[0]}), 16'h1);
		wt();
		chk(status_word, 16'h2000);
		cmd(fsr_pkg::OP_RESUME, 3'h0, 24'h0);
		chk(status_word, 16'h2000);
		for (int k = 0; k < 4; k++)
		begin
			wren();
			cmd(fsr_pkg::OP_SEC_ERASE, 3'h1, sec_addr[k]);
			rdsr();
			chk(16'(q[15:8]), k < 2 ? 16'h03 : 16'h02);
			wt();
			chk(status_word, k < 2 ? 16'h2000 : 16'h2002);
		end
		cmd(fsr_pkg::OP_WRDI, 3'h0, 24'h0);
		cmd(fsr_pkg::OP_SEC_ERASE, 3'h1, 24'h001000);
		chk(status_word, 16'h2000);
		wren();
		av(1'b1, fsr_pkg::REG_DATA, 32'h5A);
		cmd(fsr_pkg::OP_PP, 3'h3, 24'h000100);
		cmd(fsr_pkg::OP_SUSPEND, 3'h0, 24'h0);
		repeat (210) @(posedge ref_clk);
		chk(status_word, 16'hA000);
		wren();
		chk(status_word, 16'hA000);
		cmd(fsr_pkg::OP_READ, 3'h5, 24'h000120);
		chk(16'(refusals), 16'h3);
		power_lost <= 1'b1;
		@(posedge ref_clk);
		power_lost <= 1'b0;
		cmd(fsr_pkg::OP_RESUME, 3'h0, 24'h0);
		chk(status_word, 16'hA000);
		cmd(fsr_pkg::OP_RST_EN, 3'h0, 24'h0);
		cmd(fsr_pkg::OP_RST, 3'h0, 24'h0);
		chk(status_word, 16'h2000);
		wrap_up();
	end
endmodule
